//--- pkg/ccr_pkg.sv
//
// Contract
// R1: Offset high register holds signed word bits 23:8
// R2: Offset low bits 15:8; low byte reads zero
// R3: Both offset registers reset to zero
// R4: Gain high holds unsigned gain bits 23:8
// R5: Gain low bits 15:8; low byte reads zero
// R6: Gain resets to 8000h/0000h, unity gain
// R7: Setup bits 15:6 hold signed delay trim
// R8: Bit 2 disables highpass, else global setting
// R9: Bits 1:0 pick input: pins/short/pos/neg
// R10: Setup bits 5:3 read zero; reset 0000h
// R11: Writes to reserved bits are ignored
package ccr_pkg;

  // Avalon-MM shape
  localparam int AVS_ADDR_W = 8;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W   = 4;
  localparam int IDX_W      = 6;
  localparam int REG_W      = 16;
  localparam int LANES      = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OFF_HI  = 6'h14;
  localparam logic [IDX_W-1:0] IDX_OFF_LO  = 6'h15;
  localparam logic [IDX_W-1:0] IDX_GAIN_HI = 6'h16;
  localparam logic [IDX_W-1:0] IDX_GAIN_LO = 6'h17;
  localparam logic [IDX_W-1:0] IDX_SETUP   = 6'h18;

  // Field layout
  localparam int CAL_W      = 24;
  localparam int LOW_MSB    = 15;
  localparam int LOW_LSB    = 8;
  localparam int TRIM_MSB   = 15;
  localparam int TRIM_LSB   = 6;
  localparam int TRIM_W     = 10;
  localparam int RSV_MSB    = 5;
  localparam int RSV_LSB    = 3;
  localparam int HPOFF_BIT  = 2;
  localparam int SEL_MSB    = 1;
  localparam int SEL_LSB    = 0;

  // Reset values
  localparam logic [REG_W-1:0]  OFF_HI_RST  = 16'h0000;
  localparam logic [7:0]        OFF_LO_RST  = 8'h00;
  localparam logic [REG_W-1:0]  GAIN_HI_RST = 16'h8000;
  localparam logic [7:0]        GAIN_LO_RST = 8'h00;
  localparam logic [TRIM_W-1:0] TRIM_RST    = 10'h000;
  localparam logic [CAL_W-1:0]  GAIN_UNITY  = 24'h800000;

  // Input selection codes
  typedef enum logic [1:0] {
    INSEL_PINS  = 2'b00,
    INSEL_SHORT = 2'b01,
    INSEL_POS   = 2'b10,
    INSEL_NEG   = 2'b11
  } ccr_insel_t;

  // Bus handshake states
  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } ccr_bus_st_t;

endpackage

//--- pkg/ccr_acc_if.sv
`timescale 1ns/1ns
// One-cycle register access strobes between bus slave and register bank
interface ccr_acc_if;
  logic                            rd;
  logic                            wr;
  logic [ccr_pkg::IDX_W-1:0]       idx;
  logic [ccr_pkg::REG_W-1:0]       wdata;
  logic [ccr_pkg::LANES-1:0]       be;
  logic [ccr_pkg::REG_W-1:0]       rdata;

  modport bus  (output rd, output wr, output idx, output wdata, output be, input rdata);
  modport bank (input rd, input wr, input idx, input wdata, input be, output rdata);
endinterface

//--- core/ccr_avmm_slave.sv
`timescale 1ns/1ns
// Avalon-MM slave with exactly one wait state per access
module ccr_avmm_slave
  import ccr_pkg::*;
(
  input  wire logic                            mclk_in,
  input  wire logic                            resetn_in,
  input  wire logic [ccr_pkg::AVS_ADDR_W-1:0]  avs_address_in,
  input  wire logic                            avs_read_in,
  input  wire logic                            avs_write_in,
  input  wire logic [ccr_pkg::AVS_DATA_W-1:0]  avs_writedata_in,
  input  wire logic [ccr_pkg::AVS_BE_W-1:0]    avs_byteenable_in,
  output logic      [ccr_pkg::AVS_DATA_W-1:0]  avs_readdata_out,
  output logic                                 avs_waitrequest_out,
  ccr_acc_if.bus                               acc
);
  import ccr_pkg::*;

  ccr_bus_st_t                 st_q, st_d;
  logic [AVS_DATA_W-1:0]       rdat_q, rdat_d;
  logic                        req;
  logic                        aligned;

  ////////////////////////////////////////////////////////////////////////
  // Decode; misaligned addresses behave as unmapped
  assign req     = avs_read_in | avs_write_in;
  assign aligned = (avs_address_in[1:0] == 2'h0);
  assign acc.idx   = avs_address_in[AVS_ADDR_W-1:2];
  assign acc.wdata = avs_writedata_in[REG_W-1:0];
  assign acc.be    = avs_byteenable_in[LANES-1:0];
  // Strobes fire once, in the cycle waitrequest is low
  assign acc.wr = avs_write_in & aligned & (st_q == BUS_ANSWER);
  assign acc.rd = avs_read_in & aligned & (st_q == BUS_ANSWER);
  // Waitrequest is combinational so the master never waits on a stale flag
  assign avs_waitrequest_out = req & (st_q == BUS_IDLE);
  assign avs_readdata_out    = rdat_q;

  ////////////////////////////////////////////////////////////////////////
  // Handshake and read data capture; data is ready one edge before release
  always_comb begin
    st_d   = st_q;
    rdat_d = rdat_q;
    case (st_q)
      BUS_IDLE: begin
        if (req) begin
          st_d = BUS_ANSWER;
          if (avs_read_in) begin
            rdat_d = aligned ? {{(AVS_DATA_W-REG_W){1'b0}}, acc.rdata} : '0;
          end
        end
      end
      BUS_ANSWER: begin
        st_d = BUS_IDLE;
      end
      default: begin
        st_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q   <= BUS_IDLE;
      rdat_q <= '0;
    end else begin
      st_q   <= st_d;
      rdat_q <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Every request is answered on the second edge
  AST_WAIT_BOUND: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    $rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("waitrequest not released after one wait state");

endmodule

//--- core/ccr_regs.sv
`timescale 1ns/1ns
// Channel calibration and setup register bank
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic                            mclk_in,
  input  wire logic                            resetn_in,
  input  wire logic [ccr_pkg::AVS_ADDR_W-1:0]  avs_address_in,
  input  wire logic                            avs_read_in,
  input  wire logic                            avs_write_in,
  input  wire logic [ccr_pkg::AVS_DATA_W-1:0]  avs_writedata_in,
  input  wire logic [ccr_pkg::AVS_BE_W-1:0]    avs_byteenable_in,
  output logic      [ccr_pkg::AVS_DATA_W-1:0]  avs_readdata_out,
  output logic                                 avs_waitrequest_out,
  input  wire logic                            global_highpass_setting_in,
  output logic signed [ccr_pkg::CAL_W-1:0]     ch2_offset_out,
  output logic      [ccr_pkg::CAL_W-1:0]       ch2_gain_out,
  output logic signed [ccr_pkg::TRIM_W-1:0]    ch3_delay_trim_out,
  output logic                                 ch3_highpass_off_out,
  output logic                                 ch3_highpass_en_out,
  output ccr_pkg::ccr_insel_t                  ch3_input_select_out,
  output logic      [3:0]                      ch3_input_onehot_out
);
  import ccr_pkg::*;

  ccr_acc_if acc ();

  // Only writable bits are stored; reserved bits have no flops at all
  logic [REG_W-1:0]  off_hi_q,  off_hi_d;
  logic [7:0]        off_lo_q,  off_lo_d;
  logic [REG_W-1:0]  gain_hi_q, gain_hi_d;
  logic [7:0]        gain_lo_q, gain_lo_d;
  logic [TRIM_W-1:0] trim_q,    trim_d;
  logic              hpoff_q,   hpoff_d;
  ccr_insel_t        sel_q,     sel_d;
  logic [REG_W-1:0]  lane_mask;
  logic [REG_W-1:0]  setup_rd;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  ccr_avmm_slave u_slave (
    .mclk_in             (mclk_in),
    .resetn_in           (resetn_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .acc                 (acc.bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Byte lane masks from the two low byte enables
  for (genvar gl = 0; gl < LANES; gl++) begin : g_lane
    assign lane_mask[gl*8 +: 8] = {8{acc.be[gl]}};
  end

  ////////////////////////////////////////////////////////////////////////
  // Next register values; unmapped indices fall through untouched
  always_comb begin
    off_hi_d  = off_hi_q;
    off_lo_d  = off_lo_q;
    gain_hi_d = gain_hi_q;
    gain_lo_d = gain_lo_q;
    trim_d    = trim_q;
    hpoff_d   = hpoff_q;
    sel_d     = sel_q;
    if (acc.wr) begin
      case (acc.idx)
        // R1: offset upper bits
        IDX_OFF_HI: begin
          off_hi_d = (acc.wdata & lane_mask) | (off_hi_q & ~lane_mask);
        end
        // R2: offset lower byte; R11: low byte dropped
        IDX_OFF_LO: begin
          if (acc.be[1]) begin
            off_lo_d = acc.wdata[LOW_MSB:LOW_LSB];
          end
        end
        // R4: gain upper bits
        IDX_GAIN_HI: begin
          gain_hi_d = (acc.wdata & lane_mask) | (gain_hi_q & ~lane_mask);
        end
        // R5: gain lower byte; R11: low byte dropped
        IDX_GAIN_LO: begin
          if (acc.be[1]) begin
            gain_lo_d = acc.wdata[LOW_MSB:LOW_LSB];
          end
        end
        // R7: delay trim split over both lanes
        IDX_SETUP: begin
          if (acc.be[1]) begin
            trim_d[TRIM_W-1:2] = acc.wdata[TRIM_MSB:LOW_LSB];
          end
          if (acc.be[0]) begin
            trim_d[1:0] = acc.wdata[TRIM_LSB+1:TRIM_LSB];
            // R8: per-channel highpass disable
            hpoff_d = acc.wdata[HPOFF_BIT];
            // R9: input selection; R11: bits 5:3 not stored
            sel_d = ccr_insel_t'(acc.wdata[SEL_MSB:SEL_LSB]);
          end
        end
        default: begin
          off_hi_d = off_hi_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // R3: zero offset after reset
      off_hi_q  <= OFF_HI_RST;
      off_lo_q  <= OFF_LO_RST;
      // R6: unity gain after reset
      gain_hi_q <= GAIN_HI_RST;
      gain_lo_q <= GAIN_LO_RST;
      // R10: setup register clears fully
      trim_q    <= TRIM_RST;
      hpoff_q   <= 1'b0;
      sel_q     <= INSEL_PINS;
    end else begin
      off_hi_q  <= off_hi_d;
      off_lo_q  <= off_lo_d;
      gain_hi_q <= gain_hi_d;
      gain_lo_q <= gain_lo_d;
      trim_q    <= trim_d;
      hpoff_q   <= hpoff_d;
      sel_q     <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-back; reserved bits are hard zero, unmapped reads return zero
  // R10: bits 5:3 read zero
  assign setup_rd = {trim_q, 3'h0, hpoff_q, sel_q};

  always_comb begin
    case (acc.idx)
      IDX_OFF_HI:  acc.rdata = off_hi_q;
      // R2: low byte reads zero
      IDX_OFF_LO:  acc.rdata = {off_lo_q, 8'h00};
      IDX_GAIN_HI: acc.rdata = gain_hi_q;
      // R5: low byte reads zero
      IDX_GAIN_LO: acc.rdata = {gain_lo_q, 8'h00};
      IDX_SETUP:   acc.rdata = setup_rd;
      default:     acc.rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath controls, straight from flops except the highpass enable and one-hot decode
  // R1: assembled offset is two's complement
  assign ch2_offset_out       = {off_hi_q, off_lo_q};
  // R4: unsigned gain, 0.0 to just under 2.0
  assign ch2_gain_out         = {gain_hi_q, gain_lo_q};
  assign ch3_delay_trim_out   = trim_q;
  assign ch3_highpass_off_out = hpoff_q;
  // R8: follow global unless locally disabled
  assign ch3_highpass_en_out  = global_highpass_setting_in & ~hpoff_q;
  assign ch3_input_select_out = sel_q;

  // R9: one-hot routing for the input switch matrix
  for (genvar gs = 0; gs < 4; gs++) begin : g_sel
    assign ch3_input_onehot_out[gs] = (sel_q == ccr_insel_t'(gs));
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking dcb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  logic acc_wr_ok;
  logic acc_rd_ok;
  assign acc_wr_ok = avs_write_in & ~avs_waitrequest_out & (avs_address_in[1:0] == 2'h0);
  assign acc_rd_ok = avs_read_in & ~avs_waitrequest_out & (avs_address_in[1:0] == 2'h0);

  AST_OFF_HI_WRITE: assert property ( // R1
    acc_wr_ok && avs_address_in[7:2] == IDX_OFF_HI && avs_byteenable_in[1:0] == 2'h3
    |=> ch2_offset_out[CAL_W-1:8] == $past(avs_writedata_in[REG_W-1:0]))
    else $error("offset upper bits not written");

  AST_OFF_LO_WRITE: assert property ( // R2
    acc_wr_ok && avs_address_in[7:2] == IDX_OFF_LO && avs_byteenable_in[1]
    |=> ch2_offset_out[7:0] == $past(avs_writedata_in[LOW_MSB:LOW_LSB]))
    else $error("offset lower byte not written");

  AST_OFF_LO_RSVD: assert property ( // R2
    acc_rd_ok && avs_address_in[7:2] == IDX_OFF_LO |-> avs_readdata_out[7:0] == 8'h00)
    else $error("offset low reserved byte not zero");

  AST_RESET_OFFSET: assert property ( // R3
    $rose(resetn_in) |-> ch2_offset_out == 24'h000000)
    else $error("offset not zero after reset");

  AST_GAIN_HI_WRITE: assert property ( // R4
    acc_wr_ok && avs_address_in[7:2] == IDX_GAIN_HI && avs_byteenable_in[1:0] == 2'h3
    |=> ch2_gain_out[CAL_W-1:8] == $past(avs_writedata_in[REG_W-1:0]))
    else $error("gain upper bits not written");

  AST_GAIN_LO_RSVD: assert property ( // R5
    acc_rd_ok && avs_address_in[7:2] == IDX_GAIN_LO |-> avs_readdata_out[7:0] == 8'h00)
    else $error("gain low reserved byte not zero");

  AST_RESET_GAIN: assert property ( // R6
    $rose(resetn_in) |-> ch2_gain_out == GAIN_UNITY)
    else $error("gain not unity after reset");

  AST_TRIM_WRITE: assert property ( // R7
    acc_wr_ok && avs_address_in[7:2] == IDX_SETUP && avs_byteenable_in[1:0] == 2'h3
    |=> ch3_delay_trim_out == $past(avs_writedata_in[TRIM_MSB:TRIM_LSB]))
    else $error("delay trim not written");

  AST_HIGHPASS_OFF: assert property ( // R8
    acc_wr_ok && avs_address_in[7:2] == IDX_SETUP && avs_byteenable_in[0]
      && avs_writedata_in[HPOFF_BIT]
    |=> !ch3_highpass_en_out [*2])
    else $error("highpass still enabled after local disable");

  AST_INSEL_WRITE: assert property ( // R9
    acc_wr_ok && avs_address_in[7:2] == IDX_SETUP && avs_byteenable_in[0]
    |=> ch3_input_select_out == $past(avs_writedata_in[SEL_MSB:SEL_LSB])
      && $onehot(ch3_input_onehot_out))
    else $error("input selection not written");

  AST_SETUP_RSVD: assert property ( // R10
    acc_rd_ok && avs_address_in[7:2] == IDX_SETUP |-> avs_readdata_out[RSV_MSB:RSV_LSB] == 3'h0)
    else $error("setup reserved bits not zero");

  AST_RSVD_WRITE: assert property ( // R11
    acc_wr_ok && avs_address_in[7:2] == IDX_OFF_LO && avs_byteenable_in[1:0] == 2'h1
    |=> $stable(ch2_offset_out))
    else $error("reserved byte write changed offset");

  AST_GAIN_LO_WRITE: assert property ( // R5
    acc_wr_ok && avs_address_in[7:2] == IDX_GAIN_LO && avs_byteenable_in[1]
    |=> ch2_gain_out[7:0] == $past(avs_writedata_in[LOW_MSB:LOW_LSB]))
    else $error("gain lower byte not written");

  AST_GAIN_RSVD_WRITE: assert property ( // R11
    acc_wr_ok && avs_address_in[7:2] == IDX_GAIN_LO && avs_byteenable_in[1:0] == 2'h1
    |=> $stable(ch2_gain_out))
    else $error("reserved byte write changed gain");

  // Read data is captured one edge early; no write can land in between
  AST_OFF_HI_READ: assert property ( // R1
    acc_rd_ok && avs_address_in[7:2] == IDX_OFF_HI
    |-> avs_readdata_out[REG_W-1:0] == ch2_offset_out[CAL_W-1:8])
    else $error("offset upper bits read back wrong");

  AST_GAIN_HI_READ: assert property ( // R4
    acc_rd_ok && avs_address_in[7:2] == IDX_GAIN_HI
    |-> avs_readdata_out[REG_W-1:0] == ch2_gain_out[CAL_W-1:8])
    else $error("gain upper bits read back wrong");

  AST_RD_STROBE_RSVD: assert property ( // R2
    acc.rd && acc.idx == IDX_OFF_LO |-> avs_readdata_out[7:0] == 8'h00)
    else $error("offset low reserved byte not zero at read strobe");

  AST_SETUP_READ: assert property ( // R7
    acc_rd_ok && avs_address_in[7:2] == IDX_SETUP
    |-> avs_readdata_out[TRIM_MSB:TRIM_LSB] == ch3_delay_trim_out
      && avs_readdata_out[HPOFF_BIT] == ch3_highpass_off_out
      && avs_readdata_out[SEL_MSB:SEL_LSB] == ch3_input_select_out)
    else $error("setup register read back wrong");

  AST_TRIM_UPPER_KEPT: assert property ( // R7
    acc_wr_ok && avs_address_in[7:2] == IDX_SETUP && avs_byteenable_in[1:0] == 2'h1
    |=> $stable(ch3_delay_trim_out[TRIM_W-1:2]))
    else $error("delay trim upper bits changed by lane 0 write");

  AST_SETUP_UPPER_ONLY: assert property ( // R8
    acc_wr_ok && avs_address_in[7:2] == IDX_SETUP && avs_byteenable_in[1:0] == 2'h2
    |=> $stable(ch3_highpass_off_out) && $stable(ch3_input_select_out))
    else $error("lane 1 write changed highpass or input selection");

  AST_HP_FOLLOW: assert property ( // R8
    !ch3_highpass_off_out |-> ch3_highpass_en_out == global_highpass_setting_in)
    else $error("highpass does not follow global setting");

  AST_ONEHOT_MATCH: assert property ( // R9
    $onehot(ch3_input_onehot_out) && ch3_input_onehot_out[ch3_input_select_out])
    else $error("input one-hot decode does not match selection");

  AST_RESET_SETUP: assert property ( // R10
    $rose(resetn_in) |-> ch3_delay_trim_out == TRIM_RST && !ch3_highpass_off_out
      && ch3_input_select_out == INSEL_PINS)
    else $error("setup register not cleared after reset");

  COV_OFF_WRITE: cover property (acc_wr_ok && avs_address_in[7:2] == IDX_OFF_HI);
  COV_GAIN_LO:   cover property (acc_wr_ok && avs_address_in[7:2] == IDX_GAIN_LO);
  COV_GAIN_READ: cover property (acc_rd_ok && avs_address_in[7:2] == IDX_GAIN_HI);
  COV_HP_OFF:    cover property (global_highpass_setting_in && ch3_highpass_off_out);
  COV_NEG_TEST:  cover property (ch3_input_select_out == INSEL_NEG);

endmodule

//--- dv/channel_calibration_config_regs_bench.sv
`timescale 1ns/1ns
module channel_calibration_config_regs_bench;
  import ccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic                    mclk_in     = 1'b0;
  logic                    resetn_in   = 1'b0;
  logic [AVS_ADDR_W-1:0]   address     = '0;
  logic                    rd_req      = 1'b0;
  logic                    wr_req      = 1'b0;
  logic [AVS_DATA_W-1:0]   wdata       = '0;
  logic [AVS_BE_W-1:0]     be          = '0;
  logic                    glob        = 1'b0;
  logic [AVS_DATA_W-1:0]   rdata;
  logic                    waitreq;
  logic signed [CAL_W-1:0] offset;
  logic [CAL_W-1:0]        gain;
  logic signed [TRIM_W-1:0] trim;
  logic                    hp_off;
  logic                    hp_en;
  ccr_insel_t              sel;
  logic [3:0]              onehot;
  logic [65:0]             dp_now;
  int                      miscompares = 0;
  int                      checked     = 0;
  logic [15:0]             sh [5];
  logic [31:0]             rd_q [$];
  logic [65:0]             dp_q [$];
  logic                    wr_pend     = 1'b0;
  // Writable bits per register; reserved bits must stay zero
  localparam logic [15:0]  WMASK [5]   = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7};
  localparam logic [7:0]   ATAB [8]    = '{8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h51, 8'h64, 8'h4C};

  ccr_regs dut_u (
    .mclk_in                    (mclk_in),
    .resetn_in                  (resetn_in),
    .avs_address_in             (address),
    .avs_read_in                (rd_req),
    .avs_write_in               (wr_req),
    .avs_writedata_in           (wdata),
    .avs_byteenable_in          (be),
    .avs_readdata_out           (rdata),
    .avs_waitrequest_out        (waitreq),
    .global_highpass_setting_in (glob),
    .ch2_offset_out             (offset),
    .ch2_gain_out               (gain),
    .ch3_delay_trim_out         (trim),
    .ch3_highpass_off_out       (hp_off),
    .ch3_highpass_en_out        (hp_en),
    .ch3_input_select_out       (sel),
    .ch3_input_onehot_out       (onehot)
  );

  // Free-running 20 MHz clock
  always #25 mclk_in = ~mclk_in;

  assign dp_now = {offset, gain, trim, hp_off, hp_en, sel, onehot};

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of the register bank
  function automatic logic [65:0] dp_exp();
    logic [1:0] s;
    s = sh[4][1:0];
    return {sh[0], sh[1][15:8], sh[2], sh[3][15:8], sh[4][15:6], sh[4][2], glob & ~sh[4][2], s, 4'h1 << s};
  endfunction

  // Unmapped and misaligned addresses read as zero
  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    if (a[1:0] != 2'h0 || a[7:2] < IDX_OFF_HI || a[7:2] > IDX_SETUP) begin
      return 32'h0;
    end
    return {16'h0, sh[a[7:2] - IDX_OFF_HI]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing tasks
  task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_dp(input logic [65:0] e, input logic [65:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: hold the request until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
    int          n;
    int          i;
    logic [15:0] up;
    up = 16'($urandom);
    @(posedge mclk_in);
    address <= a;
    rd_req  <= !w;
    wr_req  <= w;
    wdata   <= {up, d};
    be      <= b;
    if (w) begin
      glob <= 1'($urandom);
    end else begin
      rd_q.push_back(rd_exp(a));
    end
    // Waitrequest is judged only at rising edges
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    // One fixed wait state per access
    cmp_val(32'(n), 32'd2);
    if (w && a[1:0] == 2'h0 && a[7:2] >= IDX_OFF_HI && a[7:2] <= IDX_SETUP) begin
      i = a[7:2] - IDX_OFF_HI;
      if (b[0]) sh[i][7:0] = d[7:0] & WMASK[i][7:0];
      if (b[1]) sh[i][15:8] = d[15:8] & WMASK[i][15:8];
    end
    if (w) dp_q.push_back(dp_exp());
    // Release at the accepting edge itself
    rd_req <= 1'b0;
    wr_req <= 1'b0;
  endtask

  task automatic reset_dut(input int cyc);
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (cyc) @(posedge mclk_in);
    resetn_in <= 1'b1;
    sh = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
    rd_q.delete();
    dp_q.delete();
    @(negedge mclk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: each read or write result takes the oldest note off its queue
  always @(negedge mclk_in) begin
    if (wr_pend && dp_q.size() > 0) cmp_dp(dp_q.pop_front(), dp_now);
    wr_pend = wr_req && !waitreq && resetn_in;
    if (rd_req && !waitreq && rd_q.size() > 0) cmp_val(rd_q.pop_front(), rdata);
  end

  // Watchdog: the whole run needs well under a thousand accesses
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hD827));
    reset_dut(6);
    cmp_dp(dp_exp(), dp_now);
    for (int k = 0; k < 5; k++) acc(1'b0, ATAB[k], 16'h0, 4'h3);
    // Refused places: misaligned, unmapped, below the bank
    for (int k = 5; k < 8; k++) acc(1'b1, ATAB[k], 16'hFFFF, 4'h3);
    for (int k = 5; k < 8; k++) acc(1'b0, ATAB[k], 16'h0, 4'h3);
    // All ones then readback: reserved bits must read zero
    for (int k = 0; k < 5; k++) acc(1'b1, ATAB[k], 16'hFFFF, 4'h3);
    for (int k = 0; k < 5; k++) acc(1'b0, ATAB[k], 16'h0, 4'h3);
    // Negative offset and delay trim, gain near two
    acc(1'b1, 8'h50, 16'h8000, 4'h3);
    acc(1'b1, 8'h54, 16'h0100, 4'h3);
    acc(1'b1, 8'h58, 16'hFFFF, 4'h3);
    acc(1'b1, 8'h5C, 16'hFF00, 4'h3);
    acc(1'b1, 8'h60, 16'h8000, 4'h3);
    // every input code with highpass both ways
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 8'h60, {10'($urandom), 3'b111, k[0], k[2:1]}, 4'h3);
      acc(1'b0, 8'h60, 16'h0, 4'h3);
    end
    // Random addresses, data and byte lanes, back to back
    for (int k = 0; k < 40; k++) begin
      acc(1'b1, ATAB[$urandom_range(7)], 16'($urandom), 4'($urandom));
      acc(1'b0, ATAB[$urandom_range(7)], 16'h0, 4'($urandom));
    end
    // Second reset in mid-run restores every default
    reset_dut(2);
    cmp_dp(dp_exp(), dp_now);
    for (int k = 0; k < 5; k++) acc(1'b0, ATAB[k], 16'h0, 4'h3);
    repeat (3) @(posedge mclk_in);
    complete_run();
  end

endmodule
